// ==== verilog/sxie_params.svh ====
`ifndef SXIE_PARAMS_SVH
`define SXIE_PARAMS_SVH
// ----------------------------------------
// Opcode patterns, field positions and reset values
// ----------------------------------------
`define SXIE_OP_SWAP_HI 6'h0e
`define SXIE_OP_XORF_HI 6'h06
`define SXIE_OP_XORL_HI 4'hf
`define SXIE_OP_DIRL_HI 9'h000
`define SXIE_DEST_BIT 5
`define SXIE_FADDR_HI 4
`define SXIE_DIR_FIRST 3'h5
`define SXIE_DIR_RESET 8'hff
`define SXIE_W_RESET 8'h00
`define SXIE_Z_RESET 1'h0
`endif

// ==== verilog/sxie_pkg.sv ====
package sxie_pkg;
  // Decoded instruction kinds
  typedef enum logic [2:0] {SXIE_NONE, SXIE_SWAP, SXIE_DIRL, SXIE_XORL, SXIE_XORF} sxie_op_t;
endpackage

// ==== verilog/sxie_dec_if.sv ====
// Decoder to executor carrier
interface sxie_dec_if;
  sxie_pkg::sxie_op_t op;
  logic dest_file;
  logic [4:0] faddr;
  logic [7:0] lit;
  logic [2:0] port_sel;
  modport dec (output op, dest_file, faddr, lit, port_sel);
  modport exe (input op, dest_file, faddr, lit, port_sel);
endinterface

// ==== verilog/sxie_decoder.sv ====
`include "sxie_params.svh"
module sxie_decoder (
  // Instruction word
  input wire logic [11:0] i_instr,
  input wire logic i_valid,
  // Decoded fields
  sxie_dec_if.dec dec
);
  // ----------------------------------------
  // Opcode match
  // ----------------------------------------
  always_comb
  begin
    dec.op = sxie_pkg::SXIE_NONE;
    dec.dest_file = i_instr[`SXIE_DEST_BIT];
    dec.faddr = i_instr[`SXIE_FADDR_HI:0];
    dec.lit = i_instr[7:0];
    dec.port_sel = i_instr[2:0];
    if (i_valid)
    begin
      if (i_instr[11:6] == `SXIE_OP_SWAP_HI)
        dec.op = sxie_pkg::SXIE_SWAP;
      else if (i_instr[11:6] == `SXIE_OP_XORF_HI)
        dec.op = sxie_pkg::SXIE_XORF;
      else if (i_instr[11:8] == `SXIE_OP_XORL_HI)
        dec.op = sxie_pkg::SXIE_XORL;
      else if (i_instr[11:3] == `SXIE_OP_DIRL_HI && i_instr[2:0] >= `SXIE_DIR_FIRST)
        dec.op = sxie_pkg::SXIE_DIRL;
    end
  end
endmodule

// ==== verilog/sxie_exec.sv ====
`include "sxie_params.svh"
module sxie_exec (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Instruction cycle strobe and word
  input wire logic I_VALID,
  input wire logic [11:0] I_INSTR,
  // File register read port
  input wire logic [7:0] I_FILE_RDATA,
  output logic [4:0] O_FILE_ADDR,
  // File register write port
  output logic O_FILE_WE,
  output logic [7:0] O_FILE_WDATA,
  // Core state
  output logic [7:0] O_W,
  output logic O_Z,
  output logic [7:0] O_DIR_A,
  output logic [7:0] O_DIR_B,
  output logic [7:0] O_DIR_C
);
  // ----------------------------------------
  // Decoded fields
  // ----------------------------------------
  // Carrier from the decoder, one instruction wide
  sxie_dec_if dec ();

  // ----------------------------------------
  // Core state and its next values
  // ----------------------------------------
  // Accumulator
  logic [7:0] w_r;
  logic [7:0] w_nxt;
  // Zero flag
  logic z_r;
  logic z_nxt;
  // Direction registers for ports 5, 6 and 7
  logic [7:0] dir_r [0:2];
  logic [7:0] dir_nxt [0:2];

  // ----------------------------------------
  // Datapath nets
  // ----------------------------------------
  // Candidate results, one per swap or xor operation; direction load takes the accumulator
  logic [7:0] swap_val;
  logic [7:0] xorl_val;
  logic [7:0] xorf_val;
  // Selected result and where it lands
  logic [7:0] result;
  logic to_file;
  logic to_w;
  logic z_upd;
  // Direction load strobe and entry index
  logic dir_upd;
  logic [1:0] dir_idx;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  sxie_decoder u_dec (
    .i_instr(I_INSTR),
    .i_valid(I_VALID),
    .dec(dec)
  );

  // ----------------------------------------
  // Operand paths
  // ----------------------------------------
  // Nibble exchange of the addressed file
  assign swap_val = {I_FILE_RDATA[3:0], I_FILE_RDATA[7:4]};

  // Accumulator against the literal byte
  assign xorl_val = w_r ^ dec.lit;

  // Accumulator against the addressed file
  assign xorf_val = w_r ^ I_FILE_RDATA;

  // Port 5..7 folded onto entries 0..2; selections below 5 never load
  assign dir_idx = 2'(dec.port_sel - `SXIE_DIR_FIRST);

  // ----------------------------------------
  // Result select and destination decode
  // ----------------------------------------
  // Picks the result and says which state takes it
  always_comb
  begin
    result = 8'h00;
    to_file = 1'h0;
    to_w = 1'h0;
    z_upd = 1'h0;
    dir_upd = 1'h0;
    case (dec.op)
      sxie_pkg::SXIE_SWAP:
      begin
        result = swap_val;
        to_file = dec.dest_file;
        to_w = !dec.dest_file;
      end
      sxie_pkg::SXIE_DIRL:
      begin
        dir_upd = 1'h1;
      end
      sxie_pkg::SXIE_XORL:
      begin
        result = xorl_val;
        to_w = 1'h1;
        z_upd = 1'h1;
      end
      sxie_pkg::SXIE_XORF:
      begin
        result = xorf_val;
        to_file = dec.dest_file;
        to_w = !dec.dest_file;
        z_upd = 1'h1;
      end
      default:
      begin
        // Unknown words and refused port selections leave all state alone
        result = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  // Next accumulator value
  always_comb
  begin
    w_nxt = w_r;
    if (to_w)
    begin
      w_nxt = result;
    end
  end

  // Accumulator register; the new value is seen by the next word
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      w_r <= `SXIE_W_RESET;
    end
    else
    begin
      w_r <= w_nxt;
    end
  end

  // ----------------------------------------
  // Zero flag
  // ----------------------------------------
  // Swap and direction load keep the flag; only the two xor forms move it
  always_comb
  begin
    z_nxt = z_r;
    if (z_upd)
    begin
      z_nxt = (result == 8'h00);
    end
  end

  // Zero flag register
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      z_r <= `SXIE_Z_RESET;
    end
    else
    begin
      z_r <= z_nxt;
    end
  end

  // ----------------------------------------
  // Direction registers
  // ----------------------------------------
  // Next direction values; at most one entry changes per word
  always_comb
  begin
    dir_nxt = dir_r;
    if (dir_upd)
    begin
      dir_nxt[dir_idx] = w_r;
    end
  end

  // Direction registers, all pins inputs after reset
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      dir_r[0] <= `SXIE_DIR_RESET;
      dir_r[1] <= `SXIE_DIR_RESET;
      dir_r[2] <= `SXIE_DIR_RESET;
    end
    else
    begin
      dir_r <= dir_nxt;
    end
  end

  // ----------------------------------------
  // File register port
  // ----------------------------------------
  // Strobe and data stand the whole cycle; the file commits at the edge
  assign O_FILE_ADDR = dec.faddr;
  assign O_FILE_WE = to_file;
  assign O_FILE_WDATA = result;

  // ----------------------------------------
  // Core state outputs
  // ----------------------------------------
  // Registered values straight to the pins
  assign O_W = w_r;
  assign O_Z = z_r;
  assign O_DIR_A = dir_r[0];
  assign O_DIR_B = dir_r[1];
  assign O_DIR_C = dir_r[2];
endmodule

// ==== sim/sxie_exec_assertions.sv ====
module sxie_exec_chk (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Instruction
  input wire logic I_VALID,
  input wire logic [11:0] I_INSTR,
  // File port
  input wire logic [7:0] I_FILE_RDATA,
  input wire logic [4:0] O_FILE_ADDR,
  input wire logic O_FILE_WE,
  input wire logic [7:0] O_FILE_WDATA,
  // Core state
  input wire logic [7:0] O_W,
  input wire logic O_Z,
  input wire logic [7:0] O_DIR_A,
  input wire logic [7:0] O_DIR_B,
  input wire logic [7:0] O_DIR_C
);
  timeunit 1ns;
  timeprecision 100ps;
  logic swp, xf;
  logic [7:0] sw, x;
  // Decode and operand helpers
  assign swp = I_VALID && I_INSTR[11:6] == 6'h0e;
  assign xf = I_VALID && I_INSTR[11:6] == 6'h06;
  assign sw = {I_FILE_RDATA[3:0], I_FILE_RDATA[7:4]};
  assign x = O_W ^ I_FILE_RDATA;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  property p_swap; swp |=> $stable(O_Z); endproperty
  a_swap: assert property (p_swap) else $error("swap moved zero flag");
  property p_swdst;
    swp |-> (I_INSTR[5] ? O_FILE_WE && O_FILE_WDATA == sw : !O_FILE_WE)
      ##1 O_W == ($past(I_INSTR[5]) ? $past(O_W) : $past(sw));
  endproperty
  a_swdst: assert property (p_swdst) else $error("swap destination wrong");
  property p_dir; I_VALID && I_INSTR == 12'h007 |=> O_DIR_C == $past(O_W) && $stable(O_DIR_A); endproperty
  a_dir: assert property (p_dir) else $error("direction load wrong");
  property p_dira; I_VALID && I_INSTR == 12'h005 |=> O_DIR_A == $past(O_W) && $stable(O_DIR_C); endproperty
  a_dira: assert property (p_dira) else $error("direction load port five wrong");
  property p_dirx;
    I_VALID && I_INSTR[11:3] == 9'h000 && I_INSTR[2:0] < 3'h5
      |=> $stable(O_DIR_A) && $stable(O_DIR_B) && $stable(O_DIR_C) && $stable(O_W) && $stable(O_Z);
  endproperty
  a_dirx: assert property (p_dirx) else $error("refused direction load changed state");
  property p_xl; I_VALID && I_INSTR[11:8] == 4'hf |=> O_W == $past(O_W ^ I_INSTR[7:0]) && O_Z == (O_W == 8'h00);
  endproperty
  a_xl: assert property (p_xl) else $error("literal xor wrong");
  property p_xz; xf |=> O_Z == ($past(x) == 8'h00); endproperty
  a_xz: assert property (p_xz) else $error("file xor zero flag wrong");
  property p_xd;
    xf |-> O_FILE_WE == I_INSTR[5] && (!I_INSTR[5] || O_FILE_WDATA == x)
      ##1 O_W == ($past(I_INSTR[5]) ? $past(O_W) : $past(x));
  endproperty
  a_xd: assert property (p_xd) else $error("file xor destination wrong");
  property p_idle; !I_VALID |-> !O_FILE_WE ##1 $stable(O_W) && $stable(O_DIR_B); endproperty
  a_idle: assert property (p_idle) else $error("state moved while idle");
  c_swap: cover property (swp && I_INSTR[5]);
  c_xf: cover property (xf && !I_INSTR[5]);
  c_zero: cover property (I_VALID && I_INSTR[11:8] == 4'hf ##1 O_Z);
  c_dir: cover property (I_VALID && I_INSTR == 12'h006);
endmodule

// ==== sim/test_swap_port_direction_load_xor_instr_exec.sv ====
module test_swap_port_direction_load_xor_instr_exec;
  timeunit 1ns;
  timeprecision 100ps;
  logic I_CLK = 0, I_RST = 1, I_VALID = 0, O_FILE_WE, O_Z, z = 0;
  logic [11:0] I_INSTR = 12'h000, c;
  logic [7:0] I_FILE_RDATA, O_FILE_WDATA, O_W, O_DIR_A, O_DIR_B, O_DIR_C, w = 8'h00, mem [32], e [32];
  logic [7:0] d [3] = '{8'hff, 8'hff, 8'hff};
  logic [11:0] cc [10] = '{12'hfb5, 12'hfaf, 12'hf1a, 12'h005, 12'h006, 12'h007, 12'h004, 12'h1a3, 12'h3a3, 12'h383};
  logic [4:0] O_FILE_ADDR;
  int errors = 0, samples_checked = 0, cyc = 0;
  sxie_exec i_sxie_exec (
    .I_CLK(I_CLK),
    .I_RST(I_RST),
    .I_VALID(I_VALID),
    .I_INSTR(I_INSTR),
    .I_FILE_RDATA(I_FILE_RDATA),
    .O_FILE_ADDR(O_FILE_ADDR),
    .O_FILE_WE(O_FILE_WE),
    .O_FILE_WDATA(O_FILE_WDATA),
    .O_W(O_W),
    .O_Z(O_Z),
    .O_DIR_A(O_DIR_A),
    .O_DIR_B(O_DIR_B),
    .O_DIR_C(O_DIR_C)
  );
  // File memory beside the block
  assign I_FILE_RDATA = mem[O_FILE_ADDR];
  initial forever #2.5 I_CLK = ~I_CLK;
  always @(posedge I_CLK)
  begin
    cyc++;
    if (!I_RST && O_FILE_WE) mem[O_FILE_ADDR] <= O_FILE_WDATA;
    if (cyc == 3000)
    begin
      errors++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(string n, logic [23:0] x, logic [23:0] g);
    samples_checked++;
    if (g !== x)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask
  // Expected result of an arithmetic instruction
  function logic [7:0] res(logic [11:0] c, logic [7:0] f);
    return c[11:8] == 4'hf ? w ^ c[7:0] : c[9] ? {f[3:0], f[7:4]} : w ^ f;
  endfunction
  task ex(logic [11:0] c);
    logic [7:0] r;
    I_INSTR = c;
    I_VALID = 1;
    r = res(c, e[c[4:0]]);
    if (c[11:8] == 4'hf || c[11:6] == 6'h06 || c[11:6] == 6'h0e)
    begin
      if (c[11:8] != 4'hf && c[5]) e[c[4:0]] = r;
      else w = r;
      if (!c[9] || c[11:8] == 4'hf) z = r == 8'h00;
    end
    if (c[11:3] == 9'h000 && c[2:0] > 3'h4) d[c[2:0] - 3'h5] = w;
    @(posedge I_CLK);
    #1;
    chk("w", {16'h0, w}, {16'h0, O_W});
    chk("z", {23'h0, z}, {23'h0, O_Z});
    chk("dir", {d[0], d[1], d[2]}, {O_DIR_A, O_DIR_B, O_DIR_C});
    chk("file", {16'h0, e[c[4:0]]}, {16'h0, mem[c[4:0]]});
  endtask
  // Corner cases first, then random traffic with idle gaps
  initial
  begin
    void'($urandom(33));
    foreach (mem[i]) mem[i] = $urandom;
    e = mem;
    repeat (6) @(posedge I_CLK);
    #1 I_RST = 0;
    foreach (cc[i]) ex(cc[i]);
    repeat (500)
    begin
      c = $urandom;
      case ($urandom % 5)
        0: c[11:6] = 6'h0e;
        1: c[11:6] = 6'h06;
        2: c[11:8] = 4'hf;
        3: c[11:3] = 9'h000;
      endcase
      if ($urandom % 8 == 0)
      begin
        I_VALID = 0;
        @(posedge I_CLK);
        #1;
      end
      ex(c);
    end
    end_of_test();
  end
endmodule
bind sxie_exec sxie_exec_chk i_sxie_exec_chk (
  .I_CLK(I_CLK),
  .I_RST(I_RST),
  .I_VALID(I_VALID),
  .I_INSTR(I_INSTR),
  .I_FILE_RDATA(I_FILE_RDATA),
  .O_FILE_ADDR(O_FILE_ADDR),
  .O_FILE_WE(O_FILE_WE),
  .O_FILE_WDATA(O_FILE_WDATA),
  .O_W(O_W),
  .O_Z(O_Z),
  .O_DIR_A(O_DIR_A),
  .O_DIR_B(O_DIR_B),
  .O_DIR_C(O_DIR_C)
);
